/* File: shared/cbp_pkg.sv */
// Purpose: shared constants and types for the compare and bridge pwm unit
// Assumes: 32-bit avalon-mm register bus, byte addresses, one word each
// Notes: register offsets, status bits, reset values, mode and output arrangement codes live here
package cbp_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_CONTROL  = 5'h00; // module_control
   localparam logic [4:0] OFS_COMPARE  = 5'h04; // compare_value
   localparam logic [4:0] OFS_DUTY_HI  = 5'h08; // duty_high_byte
   localparam logic [4:0] OFS_DEADBAND = 5'h0c; // deadband_control
   localparam logic [4:0] OFS_TIMERSEL = 5'h10; // timer_select
   localparam logic [4:0] OFS_STEERING = 5'h14; // pulse steering enables
   localparam logic [4:0] OFS_STATUS   = 5'h18; // flag, latch, running

   // status field positions
   localparam int STS_FLAG  = 0; // match_flag, write one to clear
   localparam int STS_LATCH = 1; // compare output latch
   localparam int STS_RUN   = 2; // pwm waveform running

   // values after reset
   localparam logic [7:0]  RST_CONTROL  = 8'h00;
   localparam logic [15:0] RST_COMPARE  = 16'h0000;
   localparam logic [7:0]  RST_DUTY_HI  = 8'h00;
   localparam logic [6:0]  RST_DEADBAND = 7'h00;
   localparam logic [3:0]  RST_STEERING = 4'h1;

   // mode_select codes
   localparam logic [3:0] MODE_OFF     = 4'h0; // module off
   localparam logic [3:0] MODE_TOGGLE  = 4'h2; // toggle pin on match
   localparam logic [3:0] MODE_SET     = 4'h8; // init low, set on match
   localparam logic [3:0] MODE_CLEAR   = 4'h9; // init high, clear on match
   localparam logic [3:0] MODE_SOFT    = 4'ha; // flag only
   localparam logic [3:0] MODE_SPECIAL = 4'hb; // special event trigger
   localparam logic [1:0] MODE_PWM_HI  = 2'h3; // top bits of pwm codes

   // output_config codes
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam logic [1:0] CFG_FWD    = 2'h1;
   localparam logic [1:0] CFG_HALF   = 2'h2;
   localparam logic [1:0] CFG_REV    = 2'h3;

   // module_control layout, bits 7:0
   typedef struct packed {
      logic [1:0] output_config; // bits 7:6
      logic [1:0] duty_low_bits; // bits 5:4
      logic [3:0] mode_select;   // bits 3:0
   } cbp_ctrl_type;
endpackage

/* File: rtl/cbp_deadband.sv */
// Purpose: delays the rising edge of one output by a cycle count
// Assumes: one clock cycle stands for one instruction cycle
// Notes: a pulse shorter than the delay never reaches the output
`timescale 1ns/1ps
module cbp_deadband (
   input  wire logic       clk,   // system clock
   input  wire logic       reset, // sync, active high
   input  wire logic       raw,   // undelayed active request
   input  wire logic [6:0] delay, // deadband_count
   output logic            out_q  // delayed active level
);
   logic [6:0] cnt_q; // cycles since raw rose

   // count while raw holds, release output once count reaches delay
   always_ff @(posedge clk) begin
      if (reset || !raw) begin
         cnt_q <= 7'h00;
         out_q <= 1'b0;
      end else if (cnt_q >= delay) begin
         out_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 7'h01; // short pulse stays inactive
      end
   end

   // a pulse wider than the delay must come out
   a_delay_release: assert property (@(posedge clk) disable iff (reset)
      (raw && cnt_q >= delay) |=> out_q)
      else $error("deadband output not released");
endmodule

/* File: rtl/cbp_top.sv */
// Purpose: one compare channel plus enhanced pwm with bridge outputs
// Assumes: timers are outside; their values arrive synchronous to clk
// Notes: registers on avalon-mm, waitrequest high while idle
// Summary of operation
// - compare value against timer pair, act on pin
// - match flag set with the pin action
// - zero control clears compare latch low
// - code 1010 sets flag only
// - code 1011 resets selected timer pair
// - trigger starts conversion only if converter enabled
// - ten bit duty waveform on four outputs
// - waveform waits for next period start
// - time base is timer plus two bits
// - config field picks output arrangement
// - single output follows pulse steering enables
// - half bridge drives A and complement B
// - deadband delays each rising edge in half bridge only
// - deadband over duty keeps output inactive
// - forward holds A, modulates D
// - reverse holds C, modulates B
// - mode low bits set output polarity
// - unused outputs left to other functions, except forward and reverse claim all four
// - codes 1000, 1001, 0010 set, clear, toggle
// - codes 11xx select pwm with pair polarity
// - duty joins high byte and two low bits
`timescale 1ns/1ps
module cbp_top (
   input  wire logic        clk,              // 50 mhz system clock
   input  wire logic        reset,            // sync, active high
   input  wire logic [4:0]  address,          // avalon byte address
   input  wire logic        read,             // avalon read
   input  wire logic        write,            // avalon write
   input  wire logic [31:0] writedata,        // avalon write data
   output logic      [31:0] readdata,         // avalon read data
   output logic             waitrequest,      // avalon stall
   input  wire logic [15:0] timer_pair_a,     // first compare time base
   input  wire logic [15:0] timer_pair_b,     // second compare time base
   input  wire logic [7:0]  pwm_period_timer, // 8-bit period timer
   input  wire logic [1:0]  time_base_low,    // quarter-cycle or prescaler bits
   input  wire logic [7:0]  period_limit,     // period limit value
   input  wire logic        adc_enabled,      // converter already on
   output logic [1:0]       timer_reset,      // pulse, per timer pair
   output logic             adc_start,        // pulse, start conversion
   output logic [3:0]       pin_out,          // out_d..out_a levels
   output logic [3:0]       pin_claim         // module owns out_d..out_a
);
   // software registers
   cbp_pkg::cbp_ctrl_type ctrl_q;        // module_control
   logic [15:0]           compare_value_q;  // compare_value
   logic [7:0]            duty_high_byte_q; // duty_high_byte
   logic [6:0]            deadband_count_q; // deadband_control
   logic                  timer_select_q;   // 1 picks pair b
   logic [3:0]            steering_q;       // single output enables
   logic                  match_flag_q;     // sticky match flag
   // compare path
   logic                  cmp_latch_q;      // compare output latch
   logic                  eq_prev_q;        // last cycle equal
   logic                  cmp_mode;         // a compare code is set
   logic                  cmp_eq;           // timer equals value
   logic                  cmp_event;        // first cycle of equality
   logic [15:0]           sel_timer;        // selected time base
   // pwm path
   logic                  per_prev_q;       // last cycle at limit
   logic                  per_event;        // period boundary
   logic                  pwm_on;           // pwm code selected
   logic                  run_q;            // waveform started
   logic [9:0]            duty_act_q;       // duty for this period
   logic [9:0]            time_base;        // 10-bit time base
   logic                  raw_pwm;          // active-high modulation
   logic                  db_a;             // delayed a side
   logic                  db_b;             // delayed b side
   logic [3:0]            act_d;            // active-high pin request
   logic [3:0]            pin_out_d;        // pin level with polarity
   logic [3:0]            pin_claim_d;      // ownership next
   // bus path
   logic                  req;              // read or write present
   logic                  accept;           // request completes now
   logic                  ctrl_wr;          // control written now
   logic [31:0]           rd_mux;           // read data next

   // ------------------------------------------------------------
   // avalon slave: one stall cycle, then the answer
   // ------------------------------------------------------------
   assign req    = read || write;
   assign accept = req && !waitrequest;
   assign ctrl_wr = accept && write && address == cbp_pkg::OFS_CONTROL;

   // waitrequest drops for one cycle after a request appears
   always_ff @(posedge clk) begin
      if (reset) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !(req && waitrequest);
      end
   end

   // read data selection, unmapped reads answer zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (address)
         cbp_pkg::OFS_CONTROL:  rd_mux[7:0]  = ctrl_q;
         cbp_pkg::OFS_COMPARE:  rd_mux[15:0] = compare_value_q;
         cbp_pkg::OFS_DUTY_HI:  rd_mux[7:0]  = duty_high_byte_q;
         cbp_pkg::OFS_DEADBAND: rd_mux[6:0]  = deadband_count_q;
         cbp_pkg::OFS_TIMERSEL: rd_mux[0]    = timer_select_q;
         cbp_pkg::OFS_STEERING: rd_mux[3:0]  = steering_q;
         cbp_pkg::OFS_STATUS: begin
            rd_mux[cbp_pkg::STS_FLAG]  = match_flag_q;
            rd_mux[cbp_pkg::STS_LATCH] = cmp_latch_q;
            rd_mux[cbp_pkg::STS_RUN]   = run_q;
         end
         default: rd_mux = 32'h0000_0000; // unmapped
      endcase
   end

   // read data captured in the stall cycle, stands while answered
   always_ff @(posedge clk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         readdata <= rd_mux;
      end
   end

   // register writes take effect on the accepting edge
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q           <= cbp_pkg::RST_CONTROL;
         compare_value_q  <= cbp_pkg::RST_COMPARE;
         duty_high_byte_q <= cbp_pkg::RST_DUTY_HI;
         deadband_count_q <= cbp_pkg::RST_DEADBAND;
         timer_select_q   <= 1'b0;
         steering_q       <= cbp_pkg::RST_STEERING;
      end else if (accept && write) begin
         unique case (address)
            cbp_pkg::OFS_CONTROL:  ctrl_q           <= writedata[7:0];
            cbp_pkg::OFS_COMPARE:  compare_value_q  <= writedata[15:0];
            cbp_pkg::OFS_DUTY_HI:  duty_high_byte_q <= writedata[7:0];
            cbp_pkg::OFS_DEADBAND: deadband_count_q <= writedata[6:0];
            cbp_pkg::OFS_TIMERSEL: timer_select_q   <= writedata[0];
            cbp_pkg::OFS_STEERING: steering_q       <= writedata[3:0];
            default: ; // status and unmapped: no stored value
         endcase
      end
   end

   // every request is answered exactly one cycle later
   a_bus_answer: assert property (@(posedge clk) disable iff (reset)
      (req && waitrequest) |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");

   // ------------------------------------------------------------
   // compare path
   // ------------------------------------------------------------
   // timer must be synchronous to clk, no resync done here
   assign sel_timer = timer_select_q ? timer_pair_b : timer_pair_a;
   assign cmp_eq    = sel_timer == compare_value_q;
   assign cmp_mode  = ctrl_q.mode_select == cbp_pkg::MODE_TOGGLE
                   || ctrl_q.mode_select[3:2] == 2'b10;
   // one event per stretch of equality, so toggle acts once
   assign cmp_event = cmp_mode && cmp_eq && !eq_prev_q;

   // remembers equality to find its first cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         eq_prev_q <= 1'b0;
      end else begin
         eq_prev_q <= cmp_eq;
      end
   end

   // compare latch: mode writes initialise, matches act
   always_ff @(posedge clk) begin
      if (reset) begin
         cmp_latch_q <= 1'b0;
      end else if (ctrl_wr && writedata[7:0] == 8'h00) begin
         cmp_latch_q <= 1'b0;
      end else if (ctrl_wr && writedata[3:0] == cbp_pkg::MODE_SET) begin
         cmp_latch_q <= 1'b0;
      end else if (ctrl_wr && writedata[3:0] == cbp_pkg::MODE_CLEAR) begin
         cmp_latch_q <= 1'b1;
      end else if (cmp_event) begin
         unique case (ctrl_q.mode_select)
            cbp_pkg::MODE_SET:    cmp_latch_q <= 1'b1;
            cbp_pkg::MODE_CLEAR:  cmp_latch_q <= 1'b0;
            cbp_pkg::MODE_TOGGLE: cmp_latch_q <= !cmp_latch_q;
            default: ; // flag-only and trigger leave latch
         endcase
      end
   end

   // sticky flag, set beats a same-cycle clear
   always_ff @(posedge clk) begin
      if (reset) begin
         match_flag_q <= 1'b0;
      end else if (cmp_event) begin
         match_flag_q <= 1'b1;
      end else if (accept && write && address == cbp_pkg::OFS_STATUS
                   && writedata[cbp_pkg::STS_FLAG]) begin
         match_flag_q <= 1'b0; // write one clears
      end
   end

   // special event: reset selected pair, start conversion if ready
   always_ff @(posedge clk) begin
      if (reset) begin
         timer_reset <= 2'b00;
         adc_start   <= 1'b0;
      end else begin
         timer_reset <= 2'b00;
         adc_start   <= 1'b0;
         if (cmp_event && ctrl_q.mode_select == cbp_pkg::MODE_SPECIAL) begin
            timer_reset[timer_select_q] <= 1'b1;
            adc_start <= adc_enabled;
         end
      end
   end

   a_flag_on_match: assert property (@(posedge clk) disable iff (reset)
      cmp_event |=> match_flag_q)
      else $error("match flag not set on match");
   a_set_on_match: assert property (@(posedge clk) disable iff (reset)
      (cmp_event && ctrl_q.mode_select == cbp_pkg::MODE_SET && !ctrl_wr)
      |=> cmp_latch_q)
      else $error("latch not set on match");
   a_toggle_latch: assert property (@(posedge clk) disable iff (reset)
      (cmp_event && ctrl_q.mode_select == cbp_pkg::MODE_TOGGLE && !ctrl_wr)
      |=> cmp_latch_q != $past(cmp_latch_q))
      else $error("latch did not toggle");
   a_soft_only: assert property (@(posedge clk) disable iff (reset)
      (cmp_event && ctrl_q.mode_select == cbp_pkg::MODE_SOFT && !ctrl_wr)
      |=> $stable(cmp_latch_q) && match_flag_q)
      else $error("flag-only mode moved latch");
   a_special_reset: assert property (@(posedge clk) disable iff (reset)
      (cmp_event && ctrl_q.mode_select == cbp_pkg::MODE_SPECIAL)
      |=> timer_reset != 2'b00 ##1 timer_reset == 2'b00)
      else $error("special event pulse wrong");
   a_adc_gate: assert property (@(posedge clk) disable iff (reset)
      adc_start |-> $past(adc_enabled) && $past(cmp_event))
      else $error("conversion started without converter");
   a_clear_latch: assert property (@(posedge clk) disable iff (reset)
      (ctrl_wr && writedata[7:0] == 8'h00) |=> !cmp_latch_q)
      else $error("cleared control left latch high");

   // ------------------------------------------------------------
   // pwm path
   // ------------------------------------------------------------
   assign pwm_on    = ctrl_q.mode_select[3:2] == cbp_pkg::MODE_PWM_HI;
   assign time_base = {pwm_period_timer, time_base_low};
   assign per_event = pwm_period_timer == period_limit && !per_prev_q;
   assign raw_pwm   = run_q && time_base < duty_act_q;

   // remembers limit match to find the period boundary once
   always_ff @(posedge clk) begin
      if (reset) begin
         per_prev_q <= 1'b0;
      end else begin
         per_prev_q <= pwm_period_timer == period_limit;
      end
   end

   // waveform starts only at a period boundary, duty taken there
   always_ff @(posedge clk) begin
      if (reset || !pwm_on) begin
         run_q      <= 1'b0;
         duty_act_q <= 10'h000;
      end else if (per_event) begin
         run_q      <= 1'b1;
         duty_act_q <= {duty_high_byte_q, ctrl_q.duty_low_bits};
      end
   end

   a_hold_start: assert property (@(posedge clk) disable iff (reset)
      (!pwm_on ##1 pwm_on && !per_event) |=> !run_q)
      else $error("pwm started mid period");

   // deadband for the a side and the complementary b side
   cbp_deadband u_db_a (
      .clk   (clk),
      .reset (reset),
      .raw   (raw_pwm),
      .delay (deadband_count_q),
      .out_q (db_a)
   );
   cbp_deadband u_db_b (
      .clk   (clk),
      .reset (reset),
      .raw   (run_q && !raw_pwm),
      .delay (deadband_count_q),
      .out_q (db_b)
   );

   // arrangement decode into active-high requests and ownership
   always_comb begin
      act_d       = 4'h0;
      pin_claim_d = 4'h0;
      if (pwm_on) begin
         unique case (ctrl_q.output_config)
            cbp_pkg::CFG_SINGLE: begin
               act_d       = raw_pwm ? steering_q : 4'h0;
               pin_claim_d = steering_q;
            end
            cbp_pkg::CFG_HALF: begin
               act_d       = {2'b00, db_b, db_a};
               pin_claim_d = 4'h3;
            end
            cbp_pkg::CFG_FWD: begin
               act_d       = {raw_pwm, 2'b00, run_q};
               pin_claim_d = 4'hf;
            end
            cbp_pkg::CFG_REV: begin
               act_d       = {1'b0, run_q, raw_pwm, 1'b0};
               pin_claim_d = 4'hf;
            end
         endcase
      end else if (ctrl_q.mode_select == cbp_pkg::MODE_TOGGLE
                   || ctrl_q.mode_select == cbp_pkg::MODE_SET
                   || ctrl_q.mode_select == cbp_pkg::MODE_CLEAR) begin
         act_d[0]       = cmp_latch_q;
         pin_claim_d[0] = 1'b1;
      end
   end

   // polarity per pair: bit 1 for a/c, bit 0 for b/d
   always_comb begin
      pin_out_d = act_d;
      if (pwm_on) begin
         pin_out_d[0] = act_d[0] ^ ctrl_q.mode_select[1];
         pin_out_d[2] = act_d[2] ^ ctrl_q.mode_select[1];
         pin_out_d[1] = act_d[1] ^ ctrl_q.mode_select[0];
         pin_out_d[3] = act_d[3] ^ ctrl_q.mode_select[0];
      end
   end

   // pin levels and ownership come straight from flops
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_out   <= 4'h0;
         pin_claim <= 4'h0;
      end else begin
         pin_out   <= pin_out_d;
         pin_claim <= pin_claim_d;
      end
   end

   a_fwd_pins: assert property (@(posedge clk) disable iff (reset)
      (pwm_on && run_q && ctrl_q.output_config == cbp_pkg::CFG_FWD)
      |=> pin_out[0] != $past(ctrl_q.mode_select[1])
          && pin_out[1] == $past(ctrl_q.mode_select[0])
          && pin_out[2] == $past(ctrl_q.mode_select[1]))
      else $error("forward arrangement pins wrong");
   a_rev_pins: assert property (@(posedge clk) disable iff (reset)
      (pwm_on && run_q && ctrl_q.output_config == cbp_pkg::CFG_REV)
      |=> pin_out[2] != $past(ctrl_q.mode_select[1])
          && pin_out[0] == $past(ctrl_q.mode_select[1])
          && pin_out[3] == $past(ctrl_q.mode_select[0]))
      else $error("reverse arrangement pins wrong");
   a_half_claim: assert property (@(posedge clk) disable iff (reset)
      (pwm_on && ctrl_q.output_config == cbp_pkg::CFG_HALF)
      |=> pin_claim == 4'h3)
      else $error("half bridge claims unused pins");
endmodule

/* File: dv/cbp_far_model.sv */
// Purpose: far side model, external timers and a bridge load watcher
// Assumes: every timer ticks on clk, in step with the unit
// Notes: compare timers wrap at TOP to keep runs short
`timescale 1ns/1ps
module cbp_far_model #(
   parameter logic [15:0] TOP = 16'h00ff // short wrap, arbitrary
) (
   input  wire logic        clk,          // system clock
   input  wire logic        reset,        // sync, active high
   input  wire logic [1:0]  timer_reset,  // trigger pulses
   input  wire logic [7:0]  period_limit, // period limit
   input  wire logic [3:0]  pin_out,      // unit outputs
   output logic      [15:0] tmr_a_q,      // timer pair a
   output logic      [15:0] tmr_b_q,      // timer pair b
   output logic      [7:0]  ptmr_q,       // period timer
   output logic      [1:0]  low_q,        // quarter bits
   output int               overlap_q     // cycles with a and b on
);
   // compare timers, synchronous counting, cleared by trigger
   always_ff @(posedge clk) begin
      tmr_a_q <= (reset || timer_reset[0] || tmr_a_q == TOP) ? 16'h0000
                 : tmr_a_q + 16'h0001;
      tmr_b_q <= (reset || timer_reset[1] || tmr_b_q == TOP) ? 16'h0000
                 : tmr_b_q + 16'h0001;
   end
   // period timer with two low bits below it
   always_ff @(posedge clk) begin
      low_q <= reset ? 2'h0 : low_q + 2'h1;
      if (reset) begin
         ptmr_q <= 8'h00;
      end else if (low_q == 2'h3) begin
         ptmr_q <= (ptmr_q == period_limit) ? 8'h00 : ptmr_q + 8'h01;
      end
   end
   // shoot-through watcher for an active-high half bridge
   always_ff @(posedge clk) begin
      overlap_q <= reset ? 0 : overlap_q + int'(pin_out[0] & pin_out[1]);
   end
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the compare and bridge pwm unit
// Assumes: far model supplies all timers; registers via avalon tasks
// Notes: pwm checks count active cycles, so phase does not matter
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;        // system clock
   logic        reset = 1'b1;      // sync reset
   logic [4:0]  address = 5'h00;   // bus address
   logic        read = 1'b0;       // bus read
   logic        write = 1'b0;      // bus write
   logic [31:0] writedata = 32'h0; // bus write data
   logic [31:0] readdata;          // bus read data
   logic        waitrequest;       // bus stall
   logic [15:0] tmr_a, tmr_b;      // compare timers
   logic [7:0]  ptmr;              // period timer
   logic [1:0]  low;               // time base low bits
   logic [7:0]  limit = 8'h07;     // period limit
   logic        adc_en = 1'b0;     // converter enabled
   logic [1:0]  trst;              // timer reset pulses
   logic        adc_go;            // conversion start
   logic [3:0]  pins, claim;       // outputs and ownership
   int          overlap;           // shoot-through count
   int          num_errors = 0;    // mismatches
   int          num_checks = 0;    // comparisons
   logic [31:0] q;                 // last read value
   cbp_top DUT (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .timer_pair_a(tmr_a), .timer_pair_b(tmr_b), .pwm_period_timer(ptmr),
      .time_base_low(low), .period_limit(limit), .adc_enabled(adc_en),
      .timer_reset(trst), .adc_start(adc_go), .pin_out(pins), .pin_claim(claim));
   cbp_far_model far (.clk(clk), .reset(reset), .timer_reset(trst), .period_limit(limit),
      .pin_out(pins), .tmr_a_q(tmr_a), .tmr_b_q(tmr_b), .ptmr_q(ptmr), .low_q(low),
      .overlap_q(overlap));
   // 50 mhz clock
   always #10 clk = ~clk;
   // one counted compare
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      // no local limit: only the watchdog ends a stalled transfer
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // reset values, width masking, unmapped place
   task automatic t_regs();
      logic [4:0] ofs [8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c};
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, ofs[i], 32'h0);
         chk("reset value", (ofs[i] == cbp_pkg::OFS_STEERING) ? 32'h1 : 32'h0, q);
      end
      bus(1'b1, cbp_pkg::OFS_DEADBAND, 32'hffffffff);
      bus(1'b0, cbp_pkg::OFS_DEADBAND, 32'h0);
      chk("deadband width", 32'h7f, q);
      bus(1'b1, 5'h1c, 32'hffffffff);
      bus(1'b0, 5'h1c, 32'h0);
      chk("unmapped", 32'h0, q);
   endtask
   // set, clear and toggle on match, then control cleared
   task automatic t_compare();
      logic [3:0] md [3] = '{cbp_pkg::MODE_SET, cbp_pkg::MODE_CLEAR, cbp_pkg::MODE_TOGGLE};
      logic       lv [3] = '{1'b1, 1'b0, 1'b1};
      int         n;
      bus(1'b1, cbp_pkg::OFS_COMPARE, 32'h80);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, cbp_pkg::OFS_CONTROL, {28'h0, md[i]});
         for (n = 0; pins[0] !== lv[i] && n < 600; n++) @(posedge clk);
         chk("pin level", {31'h0, lv[i]}, {31'h0, pins[0]});
         chk("match timing", 32'h82, {16'h0, tmr_a});
         chk("pin claim", 32'h1, {28'h0, claim});
         bus(1'b0, cbp_pkg::OFS_STATUS, 32'h0);
         chk("flag and latch", {30'h0, lv[i], 1'b1}, q & 32'h3);
         bus(1'b1, cbp_pkg::OFS_STATUS, 32'h1);
      end
      bus(1'b1, cbp_pkg::OFS_CONTROL, 32'h0);
      bus(1'b0, cbp_pkg::OFS_STATUS, 32'h0);
      chk("cleared latch", 32'h0, q & 32'h3);
   endtask
   // special event on each pair, then flag-only mode
   task automatic t_special();
      int n;
      adc_en <= 1'b1;
      bus(1'b1, cbp_pkg::OFS_COMPARE, 32'h40);
      bus(1'b1, cbp_pkg::OFS_CONTROL, {28'h0, cbp_pkg::MODE_SPECIAL});
      for (n = 0; trst[0] !== 1'b1 && n < 600; n++) @(posedge clk);
      chk("conversion start", 32'h1, {31'h0, adc_go});
      chk("pair a timing", 32'h41, {16'h0, tmr_a});
      chk("trigger claim", 32'h0, {28'h0, claim});
      adc_en <= 1'b0;
      bus(1'b1, cbp_pkg::OFS_TIMERSEL, 32'h1);
      for (n = 0; trst[1] !== 1'b1 && n < 600; n++) @(posedge clk);
      chk("no conversion", 32'h0, {31'h0, adc_go});
      chk("pair b timing", 32'h41, {16'h0, tmr_b});
      bus(1'b1, cbp_pkg::OFS_CONTROL, {28'h0, cbp_pkg::MODE_SOFT});
      bus(1'b1, cbp_pkg::OFS_STATUS, 32'h1);
      repeat (300) @(posedge clk);
      bus(1'b0, cbp_pkg::OFS_STATUS, 32'h0);
      chk("flag only", 32'h1, q & 32'h1);
      chk("flag only claim", 32'h0, {28'h0, claim});
      bus(1'b1, cbp_pkg::OFS_CONTROL, 32'h0);
      bus(1'b1, cbp_pkg::OFS_TIMERSEL, 32'h0);
   endtask
   // every arrangement and polarity, duty 14 of 32 ticks
   task automatic t_pwm();
      logic [7:0] ctl [7] = '{8'h2c, 8'h6c, 8'hec, 8'h6f, 8'h6d, 8'hee, 8'hac};
      logic [3:0] own [7] = '{4'h1, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3};
      int ex [7][4] = '{'{28, 0, 0, 0}, '{64, 0, 0, 28}, '{0, 28, 64, 0},
                        '{0, 64, 64, 36}, '{64, 64, 0, 36}, '{64, 28, 0, 0}, '{0, 0, 0, 0}};
      int         cnt [4];
      int         early, base;
      logic       seen;
      early = 0;
      seen = 1'b0;
      bus(1'b1, cbp_pkg::OFS_DUTY_HI, 32'h3);
      bus(1'b1, cbp_pkg::OFS_DEADBAND, 32'h14);
      while (ptmr !== 8'h01) @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, cbp_pkg::OFS_CONTROL, {24'h0, ctl[i]});
         for (int k = 0; k < 80; k++) begin
            @(posedge clk);
            seen = seen | (ptmr == limit);
            early += int'(pins[0] === 1'b1 && !seen);
         end
         cnt = '{0, 0, 0, 0};
         for (int k = 0; k < 64; k++) begin
            @(posedge clk);
            for (int j = 0; j < 4; j++) cnt[j] += int'(pins[j] === 1'b1);
         end
         chk("claim", {28'h0, own[i]}, {28'h0, claim});
         for (int j = 0; j < 4; j++) begin
            if (own[i][j]) chk("active count", ex[i][j], cnt[j]);
         end
      end
      chk("early pulse", 32'h0, early);
      bus(1'b1, cbp_pkg::OFS_DEADBAND, 32'h2);
      // let the pulse cut by the new delay pass, then four whole periods
      repeat (32) @(posedge clk);
      base = overlap;
      cnt = '{0, 0, 0, 0};
      for (int k = 0; k < 128; k++) begin
         @(posedge clk);
         for (int j = 0; j < 2; j++) cnt[j] += int'(pins[j] === 1'b1);
      end
      chk("shoot-through", base, overlap);
      chk("delayed a count", 48, cnt[0]);
      chk("delayed b count", 64, cnt[1]);
   endtask
   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_compare();
      t_special();
      t_pwm();
      wrap_up();
   end
   // watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
endmodule
